// [sar_ctl_model.sv]
`timescale 1ns/10ps
`default_nettype none
// serial master and analog comparator in front of the readout
module sar_ctl_model
    import sar_pkg::*;
(
    input wire logic start,
    input wire logic [RES_W-1:0] vin,
    input wire logic [CNT_W-1:0] n_edges,
    input wire logic [RES_W-1:0] dac_code,
    input wire logic sdo,
    input wire logic sdo_oe_n,
    output logic cs_n,
    output logic sclk,
    output logic cmp_ge,
    output logic [FRAME_W-1:0] rx,
    output logic done,
    output logic oe_err
);
    logic line;
    // a released line shows the opposite level, never a stale bit
    assign line = sdo_oe_n ? ~sdo : sdo;
    // comparator against the trial code, offset binary
    assign cmp_ge = (vin >= dac_code);
    // idle levels, clock stands still outside frames
    initial
    begin
        cs_n = 1'b1;
        sclk = 1'b0;
        rx = 16'h0000;
        done = 1'b0;
        oe_err = 1'b0;
    end
    // one frame per start request
    always @(posedge start)
    begin
        done = 1'b0;
        cs_n = 1'b0;
        #10;
        repeat (n_edges)
        begin
            sclk = 1'b1;
            #3;
            rx = {rx[FRAME_W-2:0], line};
            if (sdo_oe_n)
                oe_err = 1'b1;
            sclk = 1'b0;
            #3;
        end
        if (n_edges == END_STEP && !sdo_oe_n)
            oe_err = 1'b1;
        cs_n = 1'b1;
        done = 1'b1;
    end
endmodule : sar_ctl_model
`default_nettype wire

// [sar_fifo.sv]
`timescale 1ns/10ps
`default_nettype none
// small buffer with valid and ready on both sides
module sar_fifo #(
    parameter int W = 16,
    parameter int DEPTH = 2
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);

    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] rd_ptr_r;
    logic [CW-1:0] cnt_r;
    logic push;
    logic pop;

    // handshakes
    assign push = in_valid && (cnt_r != CW'(DEPTH));
    assign pop = out_valid && out_ready;
    assign in_ready = (cnt_r != CW'(DEPTH));
    assign out_valid = (cnt_r != '0);
    assign out_data = mem[rd_ptr_r];

    // storage
    always_ff @(posedge clk)
    begin
        if (push)
            mem[wr_ptr_r] <= in_data;
    end

    // pointers with wrap at depth
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
        end
        else
        begin
            if (push)
                wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + AW'(1);
            if (pop)
                rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + AW'(1);
        end
    end

    // fill level
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            cnt_r <= '0;
        else if (push && !pop)
            cnt_r <= cnt_r + CW'(1);
        else if (pop && !push)
            cnt_r <= cnt_r - CW'(1);
    end

endmodule : sar_fifo
`default_nettype wire

// [sar_pkg.sv]
`default_nettype none
// shared constants and types of the serial converter readout
package sar_pkg;

    // converter and frame geometry
    localparam int RES_W = 12;
    localparam int LEAD_W = 4;
    localparam int FRAME_W = 16;
    localparam int CNT_W = 5;

    // falling-edge counts inside one frame
    localparam logic [CNT_W-1:0] TRIAL_STEP = 5'h02;
    localparam logic [CNT_W-1:0] MSB_STEP = 5'h04;
    localparam logic [CNT_W-1:0] LSB_STEP = 5'h0f;
    localparam logic [CNT_W-1:0] END_STEP = 5'h10;
    localparam logic [CNT_W-1:0] IDX_BASE = 5'h0e;

    // successive approximation start value and reset values
    localparam logic [RES_W-1:0] TRIAL_MID = 12'h800;
    localparam logic [RES_W-1:0] CODE_RST = 12'h000;
    localparam logic [LEAD_W-1:0] LEAD_ZERO = 4'h0;

    // quiet time between frames, rounded up to core cycles
    localparam int CORE_MHZ = 125;
    localparam int QUIET_NS = 60;
    localparam int QUIET_W = 4;
    localparam logic [QUIET_W-1:0] QUIET_CYC = QUIET_W'((QUIET_NS * CORE_MHZ + 999) / 1000);

    // one readout frame as seen by the core side
    typedef struct packed {
        logic [LEAD_W-1:0] lead;
        logic [RES_W-1:0] code;
    } sar_word_t;

    // frame watch of the select line in the core domain
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_FRAME,
        ST_QUIET
    } sar_cs_st_t;

endpackage : sar_pkg
`default_nettype wire

// [sar_readout.sv]
// Contract
// RL1 - select falling starts a new conversion
// RL2 - select stays low for whole frame
// RL3 - output changes on each serial clock fall
// RL4 - four zeros then twelve result bits
// RL5 - result sent most significant bit first
// RL6 - result coded as twos complement
// RL7 - serial clock also steps the conversion
// RL8 - midscale: all ones to all zeros
// RL9 - top code is 011...111
// RL10 - bottom code is 100...000
// RL11 - controller keeps quiet time between frames
// RL12 - output released outside frame and after last
// RL13 - controller gives sixteen falling edges per frame
`timescale 1ns/10ps
`default_nettype none
module sar_readout
    import sar_pkg::*;
#(
    parameter int BUF_DEPTH = 2
) (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic cmp_ge,
    output logic [RES_W-1:0] dac_code,
    output logic serial_result_out,
    output logic serial_result_oe_n,
    output logic res_valid,
    input wire logic res_ready,
    output sar_word_t res_word,
    output logic res_overrun,
    output logic quiet_viol,
    output logic frame_busy
);

    // link domain state
    logic frame_rst_n;
    logic [CNT_W-1:0] cnt_r;
    logic [RES_W-1:0] code_r;
    logic [RES_W-1:0] code_nxt;
    logic [RES_W-1:0] dac_nxt;
    logic [3:0] bit_idx;
    logic deciding;
    logic done_r;
    logic done_tgl_r;
    sar_word_t hold_r;

    // core domain state
    logic tgl_s;
    logic cs_s;
    logic tgl_seen_r;
    logic new_word;
    logic fifo_in_ready;
    logic [QUIET_W-1:0] qcnt_r;
    sar_cs_st_t cs_st_r;
    sar_word_t fifo_out;

    // offset binary to twos complement, sign bit inverted
    function automatic logic [RES_W-1:0] to_twos(input logic [RES_W-1:0] ob);
        to_twos = {~ob[RES_W-1], ob[RES_W-2:0]};
    endfunction : to_twos

    // ---- link side, clocked by the falling serial clock ----

    // RL2 frame bounds
    // select high holds the frame logic idle, so each low period is one frame
    assign frame_rst_n = arst_n & ~cs_n;

    // RL7 clock steps conversion
    // one step per falling edge, parks after the sixteenth
    always_ff @(negedge sclk or negedge frame_rst_n)
    begin
        if (!frame_rst_n)
            cnt_r <= '0;
        else if (cnt_r != END_STEP)
            cnt_r <= cnt_r + 5'h01;
    end

    // bit under decision in this step, most significant first
    always_comb
    begin
        deciding = (cnt_r > TRIAL_STEP) && (cnt_r < LSB_STEP);
        bit_idx = 4'(IDX_BASE - cnt_r);
        code_nxt = code_r;
        dac_nxt = dac_code;
        if (deciding)
        begin
            code_nxt[bit_idx] = cmp_ge;
            dac_nxt[bit_idx] = cmp_ge;
            if (bit_idx != 4'h0)
                dac_nxt[bit_idx - 4'h1] = 1'b1;
        end
    end

    // RL1 conversion start
    // RL5 msb first
    // trial code loads at midscale, then one bit is settled per edge
    always_ff @(negedge sclk or negedge frame_rst_n)
    begin
        if (!frame_rst_n)
        begin
            code_r <= CODE_RST;
            dac_code <= CODE_RST;
        end
        else if (cnt_r == TRIAL_STEP)
        begin
            code_r <= CODE_RST;
            dac_code <= TRIAL_MID;
        end
        else if (deciding)
        begin
            code_r <= code_nxt;
            dac_code <= dac_nxt;
        end
    end

    // RL3 falling edge update
    // RL4 leading zeros
    // RL6 sign bit inverted
    // zero shown from select fall, decided bit shown as soon as known
    always_ff @(negedge sclk or negedge frame_rst_n)
    begin
        if (!frame_rst_n)
            serial_result_out <= 1'b0;
        else if (deciding)
            serial_result_out <= (bit_idx == 4'hb) ? ~cmp_ge : cmp_ge;
        else
            serial_result_out <= 1'b0;
    end

    // RL12 release after last
    // RL13 sixteen edges expected
    always_ff @(negedge sclk or negedge frame_rst_n)
    begin
        if (!frame_rst_n)
            done_r <= 1'b0;
        else if (cnt_r == LSB_STEP)
            done_r <= 1'b1;
    end

    // RL12 driven only inside frame
    // enable needs no clock edge at select fall, so it is gated by the pin
    assign serial_result_oe_n = cs_n | done_r;

    // RL8 midscale mapping
    // RL9 top code
    // RL10 bottom code
    // finished word held for the core, survives the select reset
    always_ff @(negedge sclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            hold_r <= '0;
            done_tgl_r <= 1'b0;
        end
        else if (!cs_n && cnt_r == 5'h0e)
        begin
            hold_r.lead <= LEAD_ZERO;
            hold_r.code <= to_twos(code_nxt);
            done_tgl_r <= ~done_tgl_r;
        end
    end

    // ---- core side ----

    // word-ready toggle and select into the core clock
    sar_sync #(.RST_VAL(1'b0)) u_tgl_sync (
        .clk(core_clk),
        .rst_n(arst_n),
        .d(done_tgl_r),
        .q(tgl_s)
    );

    sar_sync #(.RST_VAL(1'b1)) u_cs_sync (
        .clk(core_clk),
        .rst_n(arst_n),
        .d(cs_n),
        .q(cs_s)
    );

    // a toggle change means hold_r is stable and new
    assign new_word = (tgl_s != tgl_seen_r);

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            tgl_seen_r <= 1'b0;
        else
            tgl_seen_r <= tgl_s;
    end

    // BUF_DEPTH-entry buffer toward the core consumer, two entries by default
    sar_fifo #(.W(FRAME_W), .DEPTH(BUF_DEPTH)) u_buf (
        .clk(core_clk),
        .rst_n(arst_n),
        .in_valid(new_word),
        .in_ready(fifo_in_ready),
        .in_data(hold_r),
        .out_valid(res_valid),
        .out_ready(res_ready),
        .out_data(fifo_out)
    );

    assign res_word = fifo_out;

    // link cannot stall, a word arriving on a full buffer is flagged
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            res_overrun <= 1'b0;
        else
            res_overrun <= new_word && !fifo_in_ready;
    end

    // RL11 quiet time watch
    // select level tracked, quiet cycles counted after each frame
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cs_st_r <= ST_IDLE;
            qcnt_r <= '0;
            quiet_viol <= 1'b0;
        end
        else
        begin
            quiet_viol <= 1'b0;
            unique case (cs_st_r)
                ST_IDLE:
                begin
                    if (!cs_s)
                        cs_st_r <= ST_FRAME;
                end
                ST_FRAME:
                begin
                    // first high cycle already counts toward the quiet time
                    qcnt_r <= '0;
                    if (cs_s)
                    begin
                        cs_st_r <= ST_QUIET;
                        qcnt_r <= 4'h1;
                    end
                end
                ST_QUIET:
                begin
                    if (!cs_s)
                    begin
                        quiet_viol <= (qcnt_r < QUIET_CYC);
                        cs_st_r <= ST_FRAME;
                    end
                    else if (qcnt_r != QUIET_CYC)
                        qcnt_r <= qcnt_r + 4'h1;
                end
            endcase
        end
    end

    // frame activity seen by the core
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            frame_busy <= 1'b0;
        else
            frame_busy <= !cs_s;
    end

    // ---- checks ----

    a_drive_frame: assert property (@(negedge sclk) disable iff (!frame_rst_n) // RL1
        (cnt_r < END_STEP) |-> !serial_result_oe_n)
        else $error("output not driven inside frame");

    a_busy_frame: assert property (@(posedge core_clk) disable iff (!arst_n) // RL2
        $fell(cs_s) |=> frame_busy ##1 (frame_busy || cs_s))
        else $error("frame busy not following select");

    a_step_count: assert property (@(negedge sclk) disable iff (!frame_rst_n) // RL3
        (cnt_r != END_STEP && cnt_r != 5'h00) |-> cnt_r == $past(cnt_r) + 5'h01)
        else $error("step count skipped");

    a_lead_zero: assert property (@(negedge sclk) disable iff (!frame_rst_n) // RL4
        (cnt_r < MSB_STEP) |-> !serial_result_out)
        else $error("leading bit not zero");

    a_bit_order: assert property (@(negedge sclk) disable iff (!frame_rst_n) // RL5
        (cnt_r > MSB_STEP && cnt_r <= LSB_STEP) |-> serial_result_out == code_r[4'(LSB_STEP - cnt_r)])
        else $error("result bit out of order");

    a_msb_sign: assert property (@(negedge sclk) disable iff (!frame_rst_n) // RL6
        (cnt_r == MSB_STEP) |-> serial_result_out != code_r[RES_W-1])
        else $error("sign bit not inverted");

    a_trial_mid: assert property (@(negedge sclk) disable iff (!frame_rst_n) // RL7
        (cnt_r == 5'h03) |-> (dac_code == TRIAL_MID) ##1 (dac_code[RES_W-2] == 1'b1))
        else $error("trial code not at midscale");

    a_mid_code: assert property (@(negedge sclk) disable iff (!frame_rst_n) // RL8
        (cnt_r == LSB_STEP && code_r == 12'h7ff) |-> hold_r.code == 12'hfff)
        else $error("midscale code wrong");

    a_top_code: assert property (@(negedge sclk) disable iff (!frame_rst_n) // RL9
        (cnt_r == LSB_STEP && code_r == 12'hfff) |-> hold_r.code == 12'h7ff)
        else $error("top code wrong");

    a_low_code: assert property (@(negedge sclk) disable iff (!frame_rst_n) // RL10
        (cnt_r == LSB_STEP && code_r == 12'h000) |-> hold_r.code == 12'h800)
        else $error("bottom code wrong");

    a_quiet_short: assert property (@(posedge core_clk) disable iff (!arst_n) // RL11
        (cs_st_r == ST_QUIET && !cs_s && qcnt_r < QUIET_CYC) |=> quiet_viol)
        else $error("short quiet time not flagged");

    // watched on the core clock, the serial clock stops after the last edge
    a_release_last: assert property (@(posedge core_clk) disable iff (!arst_n) // RL12
        (done_r && !cs_n) |-> serial_result_oe_n && !serial_result_out)
        else $error("output not released after frame");

    a_oe_idle: assert property (@(posedge core_clk) disable iff (!arst_n) // RL12
        cs_n |-> serial_result_oe_n && !serial_result_out)
        else $error("output driven outside frame");

    a_word_lead: assert property (@(posedge core_clk) disable iff (!arst_n) // RL4
        res_valid |-> res_word.lead == LEAD_ZERO)
        else $error("buffered word lead not zero");

    a_conv_clean: assert property (@(negedge sclk) disable iff (!frame_rst_n) // RL1
        (cnt_r == 5'h01) |-> dac_code == CODE_RST)
        else $error("conversion not started clean");

    c_full_frame: cover property (@(negedge sclk) disable iff (!frame_rst_n)
        cnt_r == LSB_STEP);

    c_cut_frame: cover property (@(posedge cs_n)
        cnt_r != END_STEP && cnt_r != 5'h00);

    c_word_buffered: cover property (@(posedge core_clk) disable iff (!arst_n)
        new_word ##[1:1000] res_valid && res_ready);

    c_buffer_full: cover property (@(posedge core_clk) disable iff (!arst_n)
        !fifo_in_ready);

    c_quiet_bad: cover property (@(posedge core_clk) disable iff (!arst_n)
        quiet_viol);

endmodule : sar_readout
`default_nettype wire

// [sar_sync.sv]
`timescale 1ns/10ps
`default_nettype none
// three-stage synchroniser, output moves once stages two and three agree
module sar_sync #(
    parameter logic RST_VAL = 1'b0
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic d,
    output logic q
);

    logic s1_r;
    logic s2_r;
    logic s3_r;

    // capture chain
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s1_r <= RST_VAL;
            s2_r <= RST_VAL;
            s3_r <= RST_VAL;
        end
        else
        begin
            s1_r <= d;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // filtered level
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            q <= RST_VAL;
        else if (s2_r == s3_r)
            q <= s3_r;
    end

endmodule : sar_sync
`default_nettype wire

// [tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
module tb_top
    import sar_pkg::*;
;
    logic core_clk, arst_n, res_ready, start, qv_seen, ov_seen, busy_seen;
    logic [RES_W-1:0] vin;
    logic [CNT_W-1:0] n_edges;
    logic sclk, cs_n, cmp_ge, sdo, oe_n, res_valid, res_overrun, quiet_viol, frame_busy, done, oe_err;
    logic [RES_W-1:0] dac_code;
    logic [FRAME_W-1:0] rx;
    sar_word_t res_word;
    int n_fail = 0;
    int num_checks = 0;
    logic [RES_W-1:0] tbl [5] = '{12'h000, 12'hfff, 12'h7ff, 12'h800, 12'h123};

    sar_readout #(.BUF_DEPTH(2)) dut (.core_clk(core_clk), .arst_n(arst_n), .sclk(sclk), .cs_n(cs_n),
        .cmp_ge(cmp_ge), .dac_code(dac_code), .serial_result_out(sdo), .serial_result_oe_n(oe_n),
        .res_valid(res_valid), .res_ready(res_ready), .res_word(res_word), .res_overrun(res_overrun),
        .quiet_viol(quiet_viol), .frame_busy(frame_busy));
    sar_ctl_model u_ctl (.start(start), .vin(vin), .n_edges(n_edges), .dac_code(dac_code), .sdo(sdo),
        .sdo_oe_n(oe_n), .cs_n(cs_n), .sclk(sclk), .cmp_ge(cmp_ge), .rx(rx), .done(done), .oe_err(oe_err));

    // core clock, 8 ns
    initial
    begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    // sticky flags for the one-cycle pulses and the frame_busy level
    initial
    begin
        qv_seen = 1'b0;
        ov_seen = 1'b0;
        busy_seen = 1'b0;
    end
    always @(posedge core_clk)
    begin
        if (quiet_viol === 1'b1) qv_seen <= 1'b1;
        if (res_overrun === 1'b1) ov_seen <= 1'b1;
        if (frame_busy === 1'b1) busy_seen <= 1'b1;
    end

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task test_done;
        if (n_fail == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : test_done

    // one frame through the master, then a gap in core cycles
    task automatic frame(input logic [RES_W-1:0] v, input logic [CNT_W-1:0] n, input int gap);
        int k;
        @(negedge core_clk);
        vin = v;
        n_edges = n;
        start = 1'b1;
        @(negedge core_clk);
        start = 1'b0;
        k = 0;
        while (done !== 1'b1 && k < 100)
        begin
            @(negedge core_clk);
            k++;
        end
        check("frame done", {15'h0, done}, 16'h0001);
        repeat (gap) @(negedge core_clk);
    endtask : frame

    // wait for a word, compare, take it
    task automatic pop(input logic [15:0] exp);
        int k;
        @(negedge core_clk);
        k = 0;
        while (res_valid !== 1'b1 && k < 20)
        begin
            @(negedge core_clk);
            k++;
        end
        check("res_word", res_word, exp);
        res_ready = 1'b1;
        @(negedge core_clk);
        res_ready = 1'b0;
    endtask : pop

    task automatic scn_codes;
        foreach (tbl[i])
        begin
            frame(tbl[i], END_STEP, 12);
            check("serial frame", rx, {LEAD_ZERO, tbl[i] ^ TRIAL_MID});
            pop({LEAD_ZERO, tbl[i] ^ TRIAL_MID});
        end
        check("oe_n in frame", {15'h0, oe_err}, 16'h0000);
        check("frame_busy", {15'h0, busy_seen}, 16'h0001);
    endtask : scn_codes

    task automatic scn_abort;
        frame(12'h555, 5'h0a, 12);
        check("aborted word", {15'h0, res_valid}, 16'h0000);
        frame(12'h2a0, END_STEP, 12);
        pop({LEAD_ZERO, 12'h2a0 ^ TRIAL_MID});
    endtask : scn_abort

    task automatic scn_overrun;
        check("no early overrun", {15'h0, ov_seen}, 16'h0000);
        frame(12'h100, END_STEP, 12);
        frame(12'h200, END_STEP, 12);
        frame(12'h300, END_STEP, 12);
        check("overrun", {15'h0, ov_seen}, 16'h0001);
        pop({LEAD_ZERO, 12'h900});
        pop({LEAD_ZERO, 12'ha00});
        check("drained", {15'h0, res_valid}, 16'h0000);
    endtask : scn_overrun

    task automatic scn_quiet;
        check("no early quiet", {15'h0, qv_seen}, 16'h0000);
        frame(12'h0f0, END_STEP, 1);
        frame(12'hf0f, END_STEP, 12);
        check("quiet violation", {15'h0, qv_seen}, 16'h0001);
        pop({LEAD_ZERO, 12'h8f0});
        pop({LEAD_ZERO, 12'h70f});
    endtask : scn_quiet

    // watchdog against a hang
    initial
    begin
        #100000;
        n_fail++;
        test_done;
    end

    // reset, then the scenarios
    initial
    begin
        arst_n = 1'b0;
        res_ready = 1'b0;
        start = 1'b0;
        vin = 12'h000;
        n_edges = END_STEP;
        repeat (3) @(posedge core_clk);
        @(negedge core_clk);
        arst_n = 1'b1;
        check("oe_n idle", {15'h0, oe_n}, 16'h0001);
        scn_codes;
        scn_abort;
        scn_overrun;
        scn_quiet;
        test_done;
    end
endmodule : tb_top
`default_nettype wire
